// ---- include/dif_pkg.sv ----
`default_nettype none
package dif_pkg;
  // ==========================================================
  // Clock and timing
  localparam longint CLK_HZ          = 125_000_000;
  localparam int     PULSE_MIN_MS    = 14;
  localparam int     PULSE_CYC_DEF   = int'((PULSE_MIN_MS * CLK_HZ + 999) / 1000);
  localparam int     MS_CYC_DEF      = int'(CLK_HZ / 1000);
  localparam int     FILT_CYC        = 4;
  // ==========================================================
  // Register indices
  localparam logic [3:0] ADDR_BAND   = 4'h0;
  localparam logic [3:0] ADDR_SKIP_A = 4'h1;
  localparam logic [3:0] ADDR_SKIP_B = 4'h2;
  localparam logic [3:0] ADDR_FUNC0  = 4'h3;
  localparam logic [3:0] ADDR_FUNC4  = 4'h7;
  localparam logic [3:0] ADDR_JOG    = 4'h8;
  localparam logic [3:0] ADDR_DC_MS  = 4'h9;
  localparam logic [3:0] ADDR_DC_V   = 4'hA;
  localparam logic [3:0] ADDR_HOLD   = 4'hB;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  // ==========================================================
  // Limits, frequencies in 0.1 Hz units
  localparam logic [15:0] BAND_MAX   = 16'h03E8;
  localparam logic [15:0] FREQ_MAX   = 16'h2710;
  localparam logic [5:0]  CODE_MAX   = 6'h24;
  // ==========================================================
  // Function codes
  localparam logic [5:0] F_NONE = 6'h00, F_RESET = 6'h01, F_COAST = 6'h02, F_RST_COAST = 6'h03;
  localparam logic [5:0] F_QSTOP = 6'h04, F_DC = 6'h05, F_STOP = 6'h06, F_START = 6'h07;
  localparam logic [5:0] F_LATCH = 6'h08, F_FLIP = 6'h09, F_RUN_FLIP = 6'h0A, F_CW = 6'h0B;
  localparam logic [5:0] F_CCW = 6'h0C, F_JOG = 6'h0D, F_HOLD_REF = 6'h0E, F_HOLD_OUT = 6'h0F;
  localparam logic [5:0] F_UP = 6'h10, F_DOWN = 6'h11, F_GAP1 = 6'h12, F_BOOST = 6'h13;
  localparam logic [5:0] F_CUT = 6'h14, F_RAMP2 = 6'h15, F_SEL_LSB = 6'h16, F_SEL_MSB = 6'h17;
  localparam logic [5:0] F_PRESET_ON = 6'h18, F_GAP2 = 6'h19, F_HALT = 6'h1A, F_ACC_RUN = 6'h1B;
  localparam logic [5:0] F_PULSE_REF = 6'h1C, F_PULSE_FB = 6'h1D, F_PULSE_CNT = 6'h1E;
  localparam logic [5:0] F_SETUP_LSB = 6'h1F, F_SETUP_MSB = 6'h20, F_RST_START = 6'h21;
  localparam logic [5:0] F_ENC_REF = 6'h22, F_ENC_IN = 6'h24;
  // Reset function codes, terminal 4 down to 0
  localparam logic [4:0][5:0] FUNC_RST = {F_NONE, F_JOG, F_RST_COAST, F_FLIP, F_START};
endpackage
`default_nettype wire

// ---- hw/dif_top.sv ----
// Behaviour
// - Output frequency avoids a band around each skip point; zero width disables. Jog frequency bypasses the bands.
// - Two skip frequencies, 0 to 1000 Hz, reset to zero.
// - Each of five terminals has a function code 0..36; 0 ignores it.
// - Reset codes: start, direction flip, reset-with-coast, jog, none.
// - Pulse/encoder codes only on terminals 3,4; some stop codes restricted.
// - Pulse setpoint/feedback refused on terminal 3 when output is pulse.
// - Reset input rising edge clears alarm unless trip-locked.
// - Coast input low switches output stage off at once.
// - Reset-with-coast low coasts; alarm clear on its falling edge.
// - Quick-stop input low ramps down with quick-stop ramp.
// - DC-brake low brakes for set time only if time and voltage nonzero.
// - Ramp-stop input low decelerates on selected ramp.
// - Start input high runs, low stops.
// - Latched start held 14 ms starts and latches until a stop.
// - Direction flip high reverses, never starts, ignored in closed loop.
// - Run-with-flip starts and reverses together; off in closed loop.
// - Clockwise-only and counter-clockwise-only inputs start in one direction.
// - Jog forces jog frequency unless coast, quick stop or DC brake.
// - Hold freezes setpoint; step inputs and hold register writes change it; value retained.
// - Qualified 14 ms step pulses change held value by one; both high decreases.
// - Ramp-select low picks first ramp pair, high the second.
// - Two select bits pick one of four setpoints; enable picks stored setpoints.
// - Boost raises, cut lowers remote setpoint; both means lower.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dif_top #(
  parameter int PULSE_CYC = dif_pkg::PULSE_CYC_DEF,
  parameter int MS_CYC    = dif_pkg::MS_CYC_DEF
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic [4:0]  i_term,
  input  wire logic [15:0] i_ref_freq,
  input  wire logic        i_closed_loop,
  input  wire logic        i_pulse_out_sel,
  input  wire logic        i_alarm_trip_locked,
  output logic      [15:0] o_freq,
  output logic             o_coast,
  output logic             o_dc_brake,
  output logic             o_quick_stop,
  output logic             o_ramp_stop,
  output logic             o_run,
  output logic             o_reverse,
  output logic             o_cw_only,
  output logic             o_ccw_only,
  output logic             o_jog,
  output logic             o_alarm_clear,
  output logic             o_ramp_pair2,
  output logic      [1:0]  o_preset_sel,
  output logic             o_preset_on,
  output logic             o_boost,
  output logic             o_cut,
  output logic      [1:0]  o_setup_sel
);
  import dif_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [4:0][5:0]  func;
    logic [15:0]      bw;
    logic [15:0]      sfa;
    logic [15:0]      sfb;
    logic [15:0]      jogf;
    logic [15:0]      dc_ms;
    logic [15:0]      dc_v;
    logic [15:0]      hold;
    logic [4:0]       s1;
    logic [4:0]       s2;
    logic [4:0]       filt;
    logic [4:0]       fprev;
    logic [4:0][2:0]  deb;
    logic [4:0][20:0] cnt;
    logic [4:0]       low_ok;
    logic             latch;
    logic             holdp;
    logic             dcp;
    logic [15:0]      dc_left;
    logic [16:0]      ms_cnt;
    logic             rej;
    logic [15:0]      rdata;
    logic [15:0]      freq;
    logic             coast;
    logic             dcb;
    logic             qstop;
    logic             rstop;
    logic             run;
    logic             rev;
    logic             cw;
    logic             ccw;
    logic             jog;
    logic             aclr;
    logic             ramp2;
    logic [1:0]       psel;
    logic             pon;
    logic             boost;
    logic             cut;
    logic [1:0]       setup;
  } dif_state_type;

  dif_state_type r_reg;
  dif_state_type r_next;

  // ==========================================================
  // Helpers
  function automatic logic hi_any(input logic [4:0][5:0] f, input logic [4:0] v, input logic [5:0] c);
    hi_any = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (f[i] == c && v[i]) begin
        hi_any = 1'b1;
      end
    end
  endfunction

  function automatic logic lo_any(input logic [4:0][5:0] f, input logic [4:0] v, input logic [5:0] c);
    lo_any = hi_any(f, ~v, c);
  endfunction

  // Codes 18 and 25 do not exist and are refused like out-of-range ones
  function automatic logic code_ok(input int t, input logic [5:0] c, input logic pout);
    code_ok = (c <= CODE_MAX) && (c != F_GAP1) && (c != F_GAP2);
    if (c == F_HALT && t == 2) code_ok = 1'b0;
    if (c == F_ACC_RUN && t > 1) code_ok = 1'b0;
    if ((c == F_PULSE_REF || c == F_PULSE_FB) && (t < 3 || (t == 3 && pout))) code_ok = 1'b0;
    if (c == F_PULSE_CNT && t != 4) code_ok = 1'b0;
    if (c >= F_ENC_REF && c <= F_ENC_IN && t < 3) code_ok = 1'b0;
  endfunction

  // Snap a frequency inside the band to the nearer edge
  function automatic logic [15:0] skip_one(input logic [15:0] f, input logic [15:0] c, input logic [15:0] bw);
    logic [15:0] h;
    logic [15:0] lo;
    logic [16:0] hi;
    h = bw >> 1;
    lo = (c > h) ? c - h : 16'h0000;
    hi = {1'b0, c} + {1'b0, h};
    skip_one = f;
    if (bw != 16'h0000 && f > lo && {1'b0, f} < hi) begin
      skip_one = (f < c) ? lo : hi[15:0];
    end
  endfunction

  // ==========================================================
  // Decode of filtered terminals
  logic [4:0] rise;
  logic [4:0] fall;
  logic [4:0] qpulse;
  logic       coast_c;
  logic       dc_req;
  logic       dc_act;
  logic       qstop_c;
  logic       rstop_c;
  logic       stop_c;
  logic       start_c;
  logic       ccw_c;
  logic       jog_c;
  logic       hold_c;
  logic       up_ev;
  logic       dn_ev;
  logic       rst_ev;
  logic       fn_wr_bad;
  logic [15:0] base;

  always_comb begin
    r_next = r_reg;
    rise = r_reg.filt & ~r_reg.fprev;
    fall = ~r_reg.filt & r_reg.fprev;
    for (int i = 0; i < 5; i++) begin
      qpulse[i] = fall[i] && r_reg.cnt[i] >= 21'(PULSE_CYC) && r_reg.low_ok[i];
    end
    coast_c = lo_any(r_reg.func, r_reg.filt, F_COAST) | lo_any(r_reg.func, r_reg.filt, F_RST_COAST);
    dc_req = lo_any(r_reg.func, r_reg.filt, F_DC) && r_reg.dc_ms != 16'h0000 && r_reg.dc_v != 16'h0000;
    dc_act = dc_req && r_reg.dc_left != 16'h0000;
    qstop_c = lo_any(r_reg.func, r_reg.filt, F_QSTOP);
    rstop_c = lo_any(r_reg.func, r_reg.filt, F_STOP) | lo_any(r_reg.func, r_reg.filt, F_HALT);
    stop_c = coast_c | dc_act | qstop_c | rstop_c;
    ccw_c = hi_any(r_reg.func, r_reg.filt, F_CCW);
    // Run-with-flip relies on no other start being driven at the same time
    start_c = hi_any(r_reg.func, r_reg.filt, F_START) | hi_any(r_reg.func, r_reg.filt, F_ACC_RUN)
            | hi_any(r_reg.func, r_reg.filt, F_RST_START) | r_reg.latch
            | (hi_any(r_reg.func, r_reg.filt, F_RUN_FLIP) & ~i_closed_loop)
            | hi_any(r_reg.func, r_reg.filt, F_CW) | ccw_c;
    jog_c = hi_any(r_reg.func, r_reg.filt, F_JOG) & ~coast_c & ~qstop_c & ~dc_act;
    hold_c = hi_any(r_reg.func, r_reg.filt, F_HOLD_REF) | hi_any(r_reg.func, r_reg.filt, F_HOLD_OUT);
    up_ev = hi_any(r_reg.func, qpulse, F_UP);
    dn_ev = hi_any(r_reg.func, qpulse, F_DOWN) | (up_ev & hi_any(r_reg.func, r_reg.filt, F_DOWN));
    rst_ev = hi_any(r_reg.func, rise, F_RESET) | hi_any(r_reg.func, rise, F_RST_START)
           | hi_any(r_reg.func, fall, F_RST_COAST);
    fn_wr_bad = 1'b0;

    // ========================================================
    // Input conditioning
    r_next.s1 = i_term;
    r_next.s2 = r_reg.s1;
    r_next.fprev = r_reg.filt;
    for (int i = 0; i < 5; i++) begin
      if (r_reg.s2[i] == r_reg.filt[i]) begin
        r_next.deb[i] = 3'h0;
      end else if (r_reg.deb[i] == 3'(FILT_CYC - 1)) begin
        r_next.deb[i] = 3'h0;
        r_next.filt[i] = r_reg.s2[i];
      end else begin
        r_next.deb[i] = r_reg.deb[i] + 3'h1;
      end
      // Width counter restarts at each filtered edge and saturates
      if (rise[i] || fall[i]) begin
        r_next.cnt[i] = 21'h000001;
        if (rise[i]) r_next.low_ok[i] = r_reg.cnt[i] >= 21'(PULSE_CYC);
      end else if (r_reg.cnt[i] < 21'(PULSE_CYC)) begin
        r_next.cnt[i] = r_reg.cnt[i] + 21'h000001;
      end
    end

    // ========================================================
    // Latched start and DC brake timer
    if (stop_c) begin
      r_next.latch = 1'b0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (r_reg.func[i] == F_LATCH && r_reg.filt[i] && r_reg.cnt[i] == 21'(PULSE_CYC - 1)) begin
          r_next.latch = 1'b1;
        end
      end
    end
    r_next.dcp = dc_req;
    if (dc_req && !r_reg.dcp) begin
      r_next.dc_left = r_reg.dc_ms;
      r_next.ms_cnt = 17'h00000;
    end else if (dc_act) begin
      if (r_reg.ms_cnt == 17'(MS_CYC - 1)) begin
        r_next.ms_cnt = 17'h00000;
        r_next.dc_left = r_reg.dc_left - 16'h0001;
      end else begin
        r_next.ms_cnt = r_reg.ms_cnt + 17'h00001;
      end
    end

    // ========================================================
    // Hold value and step inputs
    r_next.holdp = hold_c;
    if (hold_c && !r_reg.holdp) begin
      r_next.hold = i_ref_freq;
    end else if (hold_c && dn_ev) begin
      if (r_reg.hold != 16'h0000) r_next.hold = r_reg.hold - 16'h0001;
    end else if (hold_c && up_ev) begin
      if (r_reg.hold < FREQ_MAX) r_next.hold = r_reg.hold + 16'h0001;
    end

    // ========================================================
    // Commands, stop priority
    r_next.coast = coast_c;
    r_next.dcb = dc_act & ~coast_c;
    r_next.qstop = qstop_c & ~coast_c & ~dc_act;
    r_next.rstop = rstop_c & ~coast_c & ~dc_act & ~qstop_c;
    r_next.run = start_c & ~stop_c;
    r_next.rev = ((hi_any(r_reg.func, r_reg.filt, F_FLIP) | hi_any(r_reg.func, r_reg.filt, F_RUN_FLIP))
                 & ~i_closed_loop) | ccw_c;
    r_next.cw = hi_any(r_reg.func, r_reg.filt, F_CW);
    r_next.ccw = ccw_c;
    r_next.jog = jog_c;
    r_next.aclr = rst_ev & ~i_alarm_trip_locked;
    r_next.ramp2 = hi_any(r_reg.func, r_reg.filt, F_RAMP2);
    r_next.psel = {hi_any(r_reg.func, r_reg.filt, F_SEL_MSB), hi_any(r_reg.func, r_reg.filt, F_SEL_LSB)};
    r_next.pon = hi_any(r_reg.func, r_reg.filt, F_PRESET_ON);
    r_next.cut = hi_any(r_reg.func, r_reg.filt, F_CUT);
    r_next.boost = hi_any(r_reg.func, r_reg.filt, F_BOOST) & ~r_next.cut;
    r_next.setup = {hi_any(r_reg.func, r_reg.filt, F_SETUP_MSB), hi_any(r_reg.func, r_reg.filt, F_SETUP_LSB)};
    base = hold_c ? r_reg.hold : i_ref_freq;
    r_next.freq = jog_c ? r_reg.jogf : skip_one(skip_one(base, r_reg.sfa, r_reg.bw), r_reg.sfb, r_reg.bw);

    // ========================================================
    // Register port; out-of-range writes keep the old value
    if (i_wr) begin
      r_next.rej = 1'b0;
      unique case (i_addr)
        ADDR_BAND: if (i_wdata <= BAND_MAX) r_next.bw = i_wdata; else r_next.rej = 1'b1;
        ADDR_SKIP_A: if (i_wdata <= FREQ_MAX) r_next.sfa = i_wdata; else r_next.rej = 1'b1;
        ADDR_SKIP_B: if (i_wdata <= FREQ_MAX) r_next.sfb = i_wdata; else r_next.rej = 1'b1;
        ADDR_JOG: if (i_wdata <= FREQ_MAX) r_next.jogf = i_wdata; else r_next.rej = 1'b1;
        ADDR_DC_MS: r_next.dc_ms = i_wdata;
        ADDR_DC_V: r_next.dc_v = i_wdata;
        ADDR_HOLD: if (i_wdata <= FREQ_MAX) r_next.hold = i_wdata; else r_next.rej = 1'b1;
        default: begin
          if (i_addr >= ADDR_FUNC0 && i_addr <= ADDR_FUNC4) begin
            for (int i = 0; i < 5; i++) begin
              if (i_addr == 4'(ADDR_FUNC0 + 4'(i))) begin
                if (i_wdata[15:6] == 10'h000 && code_ok(i, i_wdata[5:0], i_pulse_out_sel)) begin
                  r_next.func[i] = i_wdata[5:0];
                end else begin
                  fn_wr_bad = 1'b1;
                end
              end
            end
            r_next.rej = fn_wr_bad;
          end
        end
      endcase
    end
    r_next.rdata = 16'h0000;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_BAND: r_next.rdata = r_reg.bw;
        ADDR_SKIP_A: r_next.rdata = r_reg.sfa;
        ADDR_SKIP_B: r_next.rdata = r_reg.sfb;
        ADDR_JOG: r_next.rdata = r_reg.jogf;
        ADDR_DC_MS: r_next.rdata = r_reg.dc_ms;
        ADDR_DC_V: r_next.rdata = r_reg.dc_v;
        ADDR_HOLD: r_next.rdata = r_reg.hold;
        ADDR_STATUS: r_next.rdata = {r_reg.rej, hold_c, r_reg.latch, r_reg.jog, r_reg.rev, r_reg.run,
                                     r_reg.rstop, r_reg.qstop, r_reg.dcb, r_reg.coast, 1'b0, r_reg.filt};
        default: begin
          for (int i = 0; i < 5; i++) begin
            if (i_addr == 4'(ADDR_FUNC0 + 4'(i))) r_next.rdata = {10'h000, r_reg.func[i]};
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Registers; hold value survives only until reset, firmware saves it
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      r_reg <= '0;
      r_reg.func <= FUNC_RST;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign o_rdata       = r_reg.rdata;
  assign o_freq        = r_reg.freq;
  assign o_coast       = r_reg.coast;
  assign o_dc_brake    = r_reg.dcb;
  assign o_quick_stop  = r_reg.qstop;
  assign o_ramp_stop   = r_reg.rstop;
  assign o_run         = r_reg.run;
  assign o_reverse     = r_reg.rev;
  assign o_cw_only     = r_reg.cw;
  assign o_ccw_only    = r_reg.ccw;
  assign o_jog         = r_reg.jog;
  assign o_alarm_clear = r_reg.aclr;
  assign o_ramp_pair2  = r_reg.ramp2;
  assign o_preset_sel  = r_reg.psel;
  assign o_preset_on   = r_reg.pon;
  assign o_boost       = r_reg.boost;
  assign o_cut         = r_reg.cut;
  assign o_setup_sel   = r_reg.setup;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_hold_rise;
    i_ce && hold_c && !r_reg.holdp;
  endsequence
  sequence s_step_down;
    i_ce && hold_c && r_reg.holdp && dn_ev && r_reg.hold != 16'h0000;
  endsequence

  a_coast_over_all: assert property (r_reg.coast |-> !r_reg.run && !r_reg.dcb && !r_reg.qstop && !r_reg.rstop)
    else $error("coast not exclusive");
  a_coast_level: assert property (i_ce && coast_c |=> o_coast && !o_run)
    else $error("coast input ignored");
  a_skip_off: assert property (i_ce && r_reg.bw == 16'h0000 && !jog_c && !hold_c |=> o_freq == $past(i_ref_freq))
    else $error("frequency changed with zero band");
  a_jog_force: assert property (i_ce && jog_c |=> o_jog && o_freq == $past(r_reg.jogf))
    else $error("jog frequency not applied");
  a_dc_gated: assert property (i_ce && (r_reg.dc_ms == 16'h0000 || r_reg.dc_v == 16'h0000) |=> !o_dc_brake)
    else $error("dc brake without settings");
  a_func_refuse: assert property (i_ce && i_wr && i_addr == ADDR_FUNC0 + 4'h2 && i_wdata == 16'h001A
    |=> r_reg.func[2] == $past(r_reg.func[2]) && r_reg.rej)
    else $error("illegal code accepted");
  a_run_start: assert property (i_ce && start_c && !stop_c |=> o_run)
    else $error("start not followed by run");
  a_flip_closed: assert property (i_ce && i_closed_loop && !ccw_c |=> !o_reverse)
    else $error("reverse in closed loop");
  a_alarm_lock: assert property (i_ce && rst_ev && !i_alarm_trip_locked |=> o_alarm_clear ##1 !o_alarm_clear || !i_ce)
    else $error("alarm clear missing");
  a_hold_capture: assert property (s_hold_rise |=> r_reg.hold == $past(i_ref_freq))
    else $error("hold did not capture setpoint");
  a_step_down: assert property (s_step_down |=> r_reg.hold == $past(r_reg.hold) - 16'h0001)
    else $error("step down wrong");
  a_cut_wins: assert property (i_ce && hi_any(r_reg.func, r_reg.filt, F_CUT) |=> o_cut && !o_boost)
    else $error("boost beat cut");

endmodule // dif_top
`default_nettype wire

// ---- bench/dif_term_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ====
// Terminal wiring: levels change just after an edge and hold
module dif_term_model (
  input  wire logic       i_mclk,
  output logic      [4:0] o_term
);
  initial o_term = 5'h00;
  task automatic level(input int idx, input logic val);
    @(posedge i_mclk);
    o_term[idx] <= val;
  endtask
  task automatic set_all(input logic [4:0] val);
    @(posedge i_mclk);
    o_term <= val;
  endtask
  // High for cyc+1 cycles, then low for cyc, so a short pulse is never sent by accident
  task automatic pulse(input int idx, input int cyc);
    level(idx, 1'b1);
    repeat (cyc) @(posedge i_mclk);
    level(idx, 1'b0);
    repeat (cyc) @(posedge i_mclk);
  endtask
endmodule // dif_term_model
`default_nettype wire

// ---- bench/drive_input_function_decoder_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module drive_input_function_decoder_tb_top;
  import dif_pkg::*;
  localparam int PCYC = 20;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_closed_loop = 1'b0, i_pulse_out_sel = 1'b0, i_trip = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, i_ref_freq = 16'h0000;
  logic [15:0] o_rdata, o_freq;
  logic        o_coast, o_run, o_reverse, o_jog, o_ramp_stop, o_dc_brake, o_quick_stop, o_cw_only, o_ccw_only;
  logic        o_alarm_clear, o_ramp_pair2, o_preset_on, o_boost, o_cut;
  logic [1:0]  o_preset_sel, o_setup_sel;
  wire logic [4:0] i_term;
  int          errors = 0, n_compared = 0, ref_q;
  int          refs[$] = '{450, 451, 499, 500, 549, 550, 1950, 2049, 2050};
  logic [31:0] seed = 32'h305A;
  // Address, data written, value expected on read-back
  logic [3:0]  ta[10] = '{ADDR_BAND, ADDR_BAND, ADDR_SKIP_A, ADDR_SKIP_A, 4'h5, 4'h5, 4'h6, ADDR_FUNC4,
                          ADDR_FUNC0, ADDR_FUNC0};
  logic [15:0] td[10] = '{16'h03E9, 16'h03E8, 16'h2711, 16'h2710, 16'h001B, 16'h001A, 16'h001E, 16'h001E,
                          16'h0025, 16'h0012};
  logic [15:0] te[10] = '{16'h0000, 16'h03E8, 16'h0000, 16'h2710, 16'h0003, 16'h0003, 16'h000D, 16'h001E,
                          16'h0007, 16'h0007};
  always #4 i_mclk = ~i_mclk;
  dif_term_model drv (.i_mclk(i_mclk), .o_term(i_term));
  dif_top #(.PULSE_CYC(PCYC), .MS_CYC(5)) uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_term(i_term), .i_ref_freq(i_ref_freq), .i_closed_loop(i_closed_loop),
    .i_pulse_out_sel(i_pulse_out_sel), .i_alarm_trip_locked(i_trip), .o_freq(o_freq), .o_coast(o_coast),
    .o_dc_brake(o_dc_brake), .o_quick_stop(o_quick_stop), .o_ramp_stop(o_ramp_stop), .o_run(o_run),
    .o_reverse(o_reverse), .o_cw_only(o_cw_only), .o_ccw_only(o_ccw_only), .o_jog(o_jog),
    .o_alarm_clear(o_alarm_clear), .o_ramp_pair2(o_ramp_pair2), .o_preset_sel(o_preset_sel),
    .o_preset_on(o_preset_on), .o_boost(o_boost), .o_cut(o_cut), .o_setup_sel(o_setup_sel));
  // ====
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int skip1(input int f, input int c, input int bw);
    if (bw != 0 && f > c - bw / 2 && f < c + bw / 2) begin
      return (f < c) ? c - bw / 2 : c + bw / 2;
    end
    return f;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  // Filter plus sync takes about seven cycles; twelve leaves margin
  task automatic settle;
    repeat (12) @(posedge i_mclk);
    #1;
  endtask
  task automatic cfg(input logic [4:0][5:0] c);
    for (int t = 0; t < 5; t++) wr_reg(ADDR_FUNC0 + 4'(t), {10'h000, c[t]});
  endtask
  // Alarm clear is a one-cycle pulse, so count it over the whole response window
  task automatic count_clear(input int exp);
    int n;
    n = 0;
    drv.level(4, 1'b1);
    repeat (12) begin
      @(posedge i_mclk);
      #1;
      if (o_alarm_clear !== 1'b0) n++;
    end
    drv.level(4, 1'b0);
    settle;
    chk(16'(n), 16'(exp));
  endtask
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd_chk(ADDR_BAND, 16'h0000);
    rd_chk(ADDR_SKIP_B, 16'h0000);
    for (int t = 0; t < 5; t++) rd_chk(ADDR_FUNC0 + 4'(t), 16'(FUNC_RST[t]));
    rd_chk(4'hF, 16'h0000);
    flag(o_coast, 1'b1);
    for (int i = 0; i < 10; i++) begin
      wr_reg(ta[i], td[i]);
      rd_chk(ta[i], te[i]);
    end
    @(posedge i_mclk);
    i_pulse_out_sel <= 1'b1;
    wr_reg(4'h6, {10'h000, F_PULSE_REF});
    rd_chk(4'h6, 16'h000D);
    @(posedge i_mclk);
    i_pulse_out_sel <= 1'b0;
    wr_reg(4'h6, {10'h000, F_PULSE_REF});
    rd_chk(4'h6, 16'h001C);
    wr_reg(4'h6, {10'h000, F_JOG});
    wr_reg(ADDR_FUNC4, 16'h0000);
    wr_reg(ADDR_BAND, 16'h0064);
    wr_reg(ADDR_SKIP_A, 16'h01F4);
    wr_reg(ADDR_SKIP_B, 16'h07D0);
    drv.level(2, 1'b1);
    drv.level(1, 1'b1);
    settle;
    flag(o_coast, 1'b0);
    flag(o_run, 1'b0);
    flag(o_reverse, 1'b1);
    drv.level(0, 1'b1);
    settle;
    flag(o_run, 1'b1);
    // Fixed boundaries first, then random requests across both bands
    for (int k = 0; k < 9; k++) begin
      seed = xorshift(seed);
      refs.push_back(int'(seed % 32'd2600));
    end
    foreach (refs[k]) begin
      ref_q = refs[k];
      @(posedge i_mclk);
      i_ref_freq <= 16'(ref_q);
      settle;
      chk(o_freq, 16'(skip1(skip1(ref_q, 500, 100), 2000, 100)));
    end
    wr_reg(ADDR_JOG, 16'h01F4);
    drv.level(3, 1'b1);
    settle;
    flag(o_jog, 1'b1);
    chk(o_freq, 16'h01F4);
    drv.level(2, 1'b0);
    settle;
    flag(o_jog, 1'b0);
    flag(o_run, 1'b0);
    drv.level(2, 1'b1);
    drv.level(3, 1'b0);
    wr_reg(ADDR_FUNC0, 16'h0000);
    wr_reg(4'h4, {10'h000, F_STOP});
    wr_reg(ADDR_FUNC4, {10'h000, F_LATCH});
    settle;
    flag(o_run, 1'b0);
    drv.pulse(4, PCYC + 5);
    #1 flag(o_run, 1'b1);
    drv.level(1, 1'b0);
    settle;
    flag(o_run, 1'b0);
    flag(o_ramp_stop, 1'b1);
    // Level functions against random terminal patterns
    cfg({F_CW, F_SETUP_MSB, F_SEL_LSB, F_RAMP2, F_PRESET_ON});
    for (int k = 0; k < 4; k++) begin
      seed = xorshift(seed);
      drv.set_all(seed[4:0]);
      settle;
      chk({8'h00, o_run, o_cw_only, o_setup_sel, o_preset_sel, o_ramp_pair2, o_preset_on},
          {8'h00, seed[4], seed[4], seed[3], 2'b00, seed[2], seed[1], seed[0]});
    end
    // Stop priority, direction restriction, boost and cut
    wr_reg(ADDR_DC_MS, 16'h0002);
    wr_reg(ADDR_DC_V, 16'h0001);
    drv.set_all(5'h1F);
    cfg({F_DC, F_CCW, F_QSTOP, F_BOOST, F_CUT});
    settle;
    chk({11'h000, o_run, o_ccw_only, o_cw_only, o_cut, o_boost}, 16'h001A);
    drv.level(0, 1'b0);
    drv.level(2, 1'b0);
    settle;
    chk({11'h000, o_run, o_quick_stop, o_dc_brake, o_cut, o_boost}, 16'h0009);
    drv.level(4, 1'b0);
    settle;
    chk({14'h0000, o_quick_stop, o_dc_brake}, 16'h0001);
    settle;
    chk({14'h0000, o_quick_stop, o_dc_brake}, 16'h0002);
    // Hold, step pulses, run with flip, freeze, alarm clear
    drv.set_all(5'h00);
    cfg({F_RESET, F_DOWN, F_UP, F_RUN_FLIP, F_HOLD_REF});
    @(posedge i_mclk);
    i_ref_freq <= 16'h04D2;
    drv.level(0, 1'b1);
    settle;
    @(posedge i_mclk);
    i_ref_freq <= 16'h0000;
    settle;
    chk(o_freq, 16'h04D2);
    drv.pulse(2, PCYC + 5);
    rd_chk(ADDR_HOLD, 16'h04D3);
    drv.level(3, 1'b1);
    drv.pulse(2, PCYC + 5);
    rd_chk(ADDR_HOLD, 16'h04D2);
    drv.level(3, 1'b0);
    settle;
    rd_chk(ADDR_HOLD, 16'h04D1);
    @(posedge i_mclk);
    i_closed_loop <= 1'b1;
    drv.level(1, 1'b1);
    settle;
    chk({14'h0000, o_run, o_reverse}, 16'h0000);
    @(posedge i_mclk);
    i_closed_loop <= 1'b0;
    settle;
    chk({14'h0000, o_run, o_reverse}, 16'h0003);
    @(posedge i_mclk);
    i_ce <= 1'b0;
    drv.level(1, 1'b0);
    settle;
    flag(o_run, 1'b1);
    @(posedge i_mclk);
    i_ce <= 1'b1;
    settle;
    flag(o_run, 1'b0);
    @(posedge i_mclk);
    i_trip <= 1'b1;
    count_clear(0);
    @(posedge i_mclk);
    i_trip <= 1'b0;
    count_clear(1);
    complete_run;
  end
  // Run needs about 850 cycles; over twenty times that means a hang
  initial begin
    #(8 * 20000);
    errors++;
    complete_run;
  end
endmodule // drive_input_function_decoder_tb_top
`default_nettype wire
